// ===== logic/almost_full_pkg.sv
// Shared constants for the almost-full flag and echo clock block
package almost_full_pkg;
	localparam int          NUM_FIFO      = 4;
	localparam int          DEPTH_WORDS   = 32768;
	localparam int          LEVEL_W       = 16;
	localparam int          ADDR_W        = 8;
	localparam int          EVT_W         = NUM_FIFO;
	localparam int          NUM_SYNC      = 5;
	// Index of each pin in the synchroniser bank
	localparam int          SY_WCLK       = 0;
	localparam int          SY_RCLK       = 1;
	localparam int          SY_WEN        = 2;
	localparam int          SY_REN        = 3;
	localparam int          SY_RSEL_N     = 4;
	// Register byte addresses
	localparam logic [7:0]  OFFSET0_ADDR  = 8'h00;
	localparam logic [7:0]  CTRL_ADDR     = 8'h10;
	localparam logic [7:0]  STATUS_ADDR   = 8'h14;
	localparam logic [7:0]  LEVEL_A_ADDR  = 8'h18;
	localparam logic [7:0]  LEVEL_B_ADDR  = 8'h1C;
	// Control register fields
	localparam int          CTRL_TIMING   = 0;
	localparam int          CTRL_MODE     = 1;
	localparam int          CTRL_QUAD     = 2;
	localparam int          CTRL_MRST     = 3;
	localparam int          CTRL_WSDR_LSB = 4;
	localparam int          CTRL_RSDR_LSB = 8;
	// Status register fields
	localparam int          STAT_FIRST_WORD_FALLTHROUGH_MODE     = 4;
	localparam int          STAT_QUAD     = 5;
	// Reset values and response codes
	localparam logic [31:0] CTRL_RST      = 32'h0000_0FF5;
	localparam logic [15:0] OFFSET_RST    = 16'h007F;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage

// ===== logic/almost_full_unit.sv
// Fill counter and almost-full flag of one FIFO
`timescale 1ns/10ps
module almost_full_unit
	import almost_full_pkg::*;
#(
	parameter int DEPTH = DEPTH_WORDS
)(
	input  wire logic               clk_i,          // System clock
	input  wire logic               reset_i,        // Async reset, active high
	input  wire logic               clear_i,        // Master reset pulse
	input  wire logic               enable_i,       // FIFO active in this mode
	input  wire logic               first_word_fallthrough_mode_i,         // Fall-through mode
	input  wire logic               sync_mode_i,    // Synchronous flag timing
	input  wire logic               wr_sdr_i,       // Write port single rate
	input  wire logic               rd_sdr_i,       // Read port single rate
	input  wire logic [15:0]        offset_i,       // Full offset m
	input  wire logic               wr_rise_i,      // Write clock rising edge
	input  wire logic               wr_fall_i,      // Write clock falling edge
	input  wire logic               wr_en_i,        // Write requested
	input  wire logic               rd_rise_i,      // Read clock rising edge
	input  wire logic               rd_fall_i,      // Read clock falling edge
	input  wire logic               rd_en_i,        // Read requested
	output logic                    almost_full_n_o, // Almost-full flag, low active
	output logic [LEVEL_W-1:0]      level_o,        // Fill level, write view
	output logic [LEVEL_W-1:0]      rd_view_o       // Fill level, read view
);
	typedef struct packed {
		logic [LEVEL_W-1:0] level;
		logic [LEVEL_W-1:0] rd_view;
		logic               flag;
	} unit_state_type;

	unit_state_type st_ff;
	unit_state_type nxt_st;
	logic [16:0]    thr;
	logic [16:0]    thr_std;
	logic [16:0]    thr_fw;
	logic [16:0]    cap;
	logic           wr_edge;
	logic           rd_edge;
	logic           rd_ref;
	logic           wr_ref;
	logic           wr_do;
	logic           rd_do;

	// Thresholds from this FIFO's own offset
	assign thr_std = 17'(DEPTH) - {1'b0, offset_i};
	assign thr_fw  = 17'(DEPTH) + 17'h0_0001 - {1'b0, offset_i};
	assign thr     = first_word_fallthrough_mode_i ? thr_fw : thr_std;
	assign cap     = first_word_fallthrough_mode_i ? 17'(DEPTH) + 17'h0_0001 : 17'(DEPTH);
	// Data edges per port rate; crossing references per port rate
	assign wr_edge = wr_rise_i | (~wr_sdr_i & wr_fall_i);
	assign rd_edge = rd_rise_i | (~rd_sdr_i & rd_fall_i);
	assign rd_ref  = rd_sdr_i ? rd_rise_i : rd_fall_i;
	assign wr_ref  = wr_sdr_i ? wr_rise_i : wr_fall_i;
	assign wr_do   = enable_i & wr_edge & wr_en_i & ({1'b0, st_ff.level} < cap);
	assign rd_do   = enable_i & rd_edge & rd_en_i & (st_ff.level != 16'h0000);

	// Next level and flag
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.level = st_ff.level + LEVEL_W'(wr_do) - LEVEL_W'(rd_do);
		if (wr_ref)
			nxt_st.rd_view = nxt_st.level;
		if (clear_i || !enable_i)
		begin
			nxt_st.level   = '0;
			nxt_st.rd_view = '0;
			nxt_st.flag    = 1'b1;
		end
		else if (sync_mode_i)
		begin
			if (wr_rise_i)
				nxt_st.flag = ({1'b0, nxt_st.level} < thr);
		end
		else
		begin
			if (wr_rise_i && ({1'b0, nxt_st.level} >= thr))
				nxt_st.flag = 1'b0;
			else if (rd_ref && ({1'b0, nxt_st.level} < thr))
				nxt_st.flag = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			st_ff <= '{level: '0, rd_view: '0, flag: 1'b1};
		else
			st_ff <= nxt_st;
	end

	assign almost_full_n_o = st_ff.flag;
	assign level_o         = st_ff.level;
	assign rd_view_o       = st_ff.rd_view;

	property p_clear_high;
		@(posedge clk_i) disable iff (reset_i)
		clear_i |=> almost_full_n_o && (level_o == 16'h0000);
	endproperty
	a_clear_high: assert property (p_clear_high)
		else $error("flag not high after clear");

	property p_sync_stable;
		@(posedge clk_i) disable iff (reset_i)
		sync_mode_i && enable_i && !wr_rise_i && !clear_i |=> $stable(almost_full_n_o);
	endproperty
	a_sync_stable: assert property (p_sync_stable)
		else $error("sync flag moved off edge");

	property p_fall_on_write;
		@(posedge clk_i) disable iff (reset_i)
		$fell(almost_full_n_o) |-> $past(wr_rise_i);
	endproperty
	a_fall_on_write: assert property (p_fall_on_write)
		else $error("flag fell without write edge");

	property p_async_release;
		@(posedge clk_i) disable iff (reset_i)
		$rose(almost_full_n_o) && $past(!sync_mode_i && enable_i && !clear_i) |-> $past(rd_ref);
	endproperty
	a_async_release: assert property (p_async_release)
		else $error("async release off read edge");

	property p_std_threshold;
		@(posedge clk_i) disable iff (reset_i)
		sync_mode_i && !first_word_fallthrough_mode_i && enable_i && !clear_i && wr_rise_i
			&& ({1'b0, level_o} >= thr_std + 17'h0_0001) |=> !almost_full_n_o;
	endproperty
	a_std_threshold: assert property (p_std_threshold)
		else $error("standard threshold missed");

	property p_first_word_fallthrough_mode_threshold;
		@(posedge clk_i) disable iff (reset_i)
		sync_mode_i && first_word_fallthrough_mode_i && enable_i && !clear_i && wr_rise_i
			&& ({1'b0, level_o} >= thr_fw + 17'h0_0001) |=> !almost_full_n_o;
	endproperty
	a_first_word_fallthrough_mode_threshold: assert property (p_first_word_fallthrough_mode_threshold)
		else $error("fall-through threshold missed");
endmodule

// ===== logic/almost_full_echo.sv
// Almost-full flags and echo read clocks for a four- or two-FIFO device
`timescale 1ns/10ps
module almost_full_echo
	import almost_full_pkg::*;
#(
	parameter int NF    = NUM_FIFO,
	parameter int DEPTH = DEPTH_WORDS
)(
	input  wire logic               clk_i,            // System clock, 100 MHz
	input  wire logic               reset_i,          // Async reset, active high
	input  wire logic [NF-1:0]      wr_clk_i,         // Write clock pins
	input  wire logic [NF-1:0]      wr_en_i,          // Write enable pins, high active
	input  wire logic [NF-1:0]      rd_clk_i,         // Read clock pins
	input  wire logic [NF-1:0]      rd_en_i,          // Read enable pins, high active
	input  wire logic [NF-1:0]      read_select_n_i,  // Read chip selects, low active
	output logic [NF-1:0]           almost_full_n_o,  // Almost-full flags, low active
	output logic [NF-1:0]           echo_read_clk_o,  // Echo read clocks
	output logic                    evt_valid_o,      // Flag change word ready
	input  wire logic               evt_ready_i,      // Receiver takes word
	output logic [EVT_W-1:0]        evt_data_o,       // Flag vector after change
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr_i,   // Write address
	input  wire logic               s_axi_awvalid_i,  // Write address valid
	output logic                    s_axi_awready_o,  // Write address ready
	input  wire logic [31:0]        s_axi_wdata_i,    // Write data
	input  wire logic [3:0]         s_axi_wstrb_i,    // Write byte strobes
	input  wire logic               s_axi_wvalid_i,   // Write data valid
	output logic                    s_axi_wready_o,   // Write data ready
	output logic [1:0]              s_axi_bresp_o,    // Write response
	output logic                    s_axi_bvalid_o,   // Write response valid
	input  wire logic               s_axi_bready_i,   // Write response ready
	input  wire logic [ADDR_W-1:0]  s_axi_araddr_i,   // Read address
	input  wire logic               s_axi_arvalid_i,  // Read address valid
	output logic                    s_axi_arready_o,  // Read address ready
	output logic [31:0]             s_axi_rdata_o,    // Read data
	output logic [1:0]              s_axi_rresp_o,    // Read response
	output logic                    s_axi_rvalid_o,   // Read data valid
	input  wire logic               s_axi_rready_i    // Read data ready
);
	typedef struct packed {
		logic [NUM_SYNC-1:0][NF-1:0] sy1;
		logic [NUM_SYNC-1:0][NF-1:0] sy2;
		logic [NUM_SYNC-1:0][NF-1:0] sy3;
		logic [NUM_SYNC-1:0][NF-1:0] filt;
		logic [NF-1:0]               echo;
		logic [NF-1:0][15:0]         offset;
		logic [31:0]                 ctrl;
		logic                        boot;
		logic                        clr;
		logic                        first_word_fallthrough_mode;
		logic                        quad;
		logic                        aw_hold;
		logic [ADDR_W-1:0]           awaddr;
		logic                        w_hold;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [1:0]                  rresp;
		logic [1:0][EVT_W-1:0]       buf_data;
		logic [1:0]                  buf_cnt;
		logic [EVT_W-1:0]            last_sent;
	} top_state_type;

	top_state_type                st_ff;
	top_state_type                nxt_st;
	logic [NUM_SYNC-1:0][NF-1:0]  rise;
	logic [NUM_SYNC-1:0][NF-1:0]  fall;
	logic [NF-1:0]                active;
	logic [NF-1:0]                flag_raw;
	logic [NF-1:0][LEVEL_W-1:0]   level;
	logic [NF-1:0][LEVEL_W-1:0]   rd_view;
	logic                         push;
	logic                         pop;
	logic [31:0]                  rd_word;
	logic                         rd_hit;
	logic [1:0]                   wr_slot;

	// Edge detection once the second and third stages agree
	always_comb
	begin
		for (int s = 0; s < NUM_SYNC; s++)
		begin
			for (int f = 0; f < NF; f++)
			begin
				rise[s][f] = (st_ff.sy2[s][f] == st_ff.sy3[s][f]) && st_ff.sy3[s][f]
					&& !st_ff.filt[s][f];
				fall[s][f] = (st_ff.sy2[s][f] == st_ff.sy3[s][f]) && !st_ff.sy3[s][f]
					&& st_ff.filt[s][f];
			end
		end
	end

	// In dual mode only FIFO0 and FIFO2 exist
	always_comb
	begin
		for (int f = 0; f < NF; f++)
			active[f] = st_ff.quad || (f % 2 == 0);
	end

	// One flag unit per FIFO
	for (genvar g = 0; g < NF; g++)
	begin : g_unit
		almost_full_unit #(
			.DEPTH(DEPTH)
		) u_unit (
			.clk_i          (clk_i),
			.reset_i        (reset_i),
			.clear_i        (st_ff.clr),
			.enable_i       (active[g]),
			.first_word_fallthrough_mode_i         (st_ff.first_word_fallthrough_mode),
			.sync_mode_i    (st_ff.ctrl[CTRL_TIMING]),
			.wr_sdr_i       (st_ff.ctrl[CTRL_WSDR_LSB + g]),
			.rd_sdr_i       (st_ff.ctrl[CTRL_RSDR_LSB + g]),
			.offset_i       (st_ff.offset[g]),
			.wr_rise_i      (rise[SY_WCLK][g]),
			.wr_fall_i      (fall[SY_WCLK][g]),
			.wr_en_i        (st_ff.filt[SY_WEN][g]),
			.rd_rise_i      (rise[SY_RCLK][g]),
			.rd_fall_i      (fall[SY_RCLK][g]),
			.rd_en_i        (st_ff.filt[SY_REN][g] && !st_ff.filt[SY_RSEL_N][g]),
			.almost_full_n_o(flag_raw[g]),
			.level_o        (level[g]),
			.rd_view_o      (rd_view[g])
		);
	end

	// Register read mux
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (s_axi_araddr_i < CTRL_ADDR && s_axi_araddr_i[1:0] == 2'b00)
			rd_word = {16'h0000, st_ff.offset[s_axi_araddr_i[3:2]]};
		else if (s_axi_araddr_i == CTRL_ADDR)
			rd_word = st_ff.ctrl;
		else if (s_axi_araddr_i == STATUS_ADDR)
		begin
			rd_word[NF-1:0]   = flag_raw;
			rd_word[STAT_FIRST_WORD_FALLTHROUGH_MODE] = st_ff.first_word_fallthrough_mode;
			rd_word[STAT_QUAD] = st_ff.quad;
		end
		else if (s_axi_araddr_i == LEVEL_A_ADDR)
			rd_word = {rd_view[1], rd_view[0]};
		else if (s_axi_araddr_i == LEVEL_B_ADDR)
			rd_word = {rd_view[3], rd_view[2]};
		else
			rd_hit = 1'b0;
	end

	// Event buffer handshakes
	assign pop     = (st_ff.buf_cnt != 2'd0) && evt_ready_i;
	assign push    = (flag_raw != st_ff.last_sent) && (st_ff.buf_cnt != 2'd2 || pop);
	assign wr_slot = st_ff.buf_cnt - 2'(pop);

	// Next state of the whole block
	always_comb
	begin
		nxt_st = st_ff;
		// Three-stage synchronisers on every pin
		nxt_st.sy1 = {read_select_n_i, rd_en_i, wr_en_i, rd_clk_i, wr_clk_i};
		nxt_st.sy2 = st_ff.sy1;
		nxt_st.sy3 = st_ff.sy2;
		for (int s = 0; s < NUM_SYNC; s++)
			for (int f = 0; f < NF; f++)
				if (st_ff.sy2[s][f] == st_ff.sy3[s][f])
					nxt_st.filt[s][f] = st_ff.sy3[s][f];
		// Echo clock trails the filtered read clock by one stage
		nxt_st.echo = st_ff.filt[SY_RCLK] & active;
		// Master reset pulse and mode capture
		nxt_st.boot = 1'b0;
		nxt_st.clr  = st_ff.boot;
		if (st_ff.clr)
		begin
			nxt_st.first_word_fallthrough_mode = st_ff.ctrl[CTRL_MODE];
			nxt_st.quad = st_ff.ctrl[CTRL_QUAD];
		end
		// Write channel: address and data taken in either order
		if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			nxt_st.aw_hold = 1'b1;
			nxt_st.awaddr  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			nxt_st.w_hold = 1'b1;
			nxt_st.wdata  = s_axi_wdata_i;
			nxt_st.wstrb  = s_axi_wstrb_i;
		end
		if (st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid)
		begin
			nxt_st.aw_hold = 1'b0;
			nxt_st.w_hold  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			nxt_st.bresp   = RESP_OKAY;
			if (st_ff.awaddr < CTRL_ADDR && st_ff.awaddr[1:0] == 2'b00)
			begin
				for (int b = 0; b < 2; b++)
					if (st_ff.wstrb[b])
						nxt_st.offset[st_ff.awaddr[3:2]][b*8 +: 8] = st_ff.wdata[b*8 +: 8];
			end
			else if (st_ff.awaddr == CTRL_ADDR)
			begin
				for (int b = 0; b < 2; b++)
					if (st_ff.wstrb[b])
						nxt_st.ctrl[b*8 +: 8] = st_ff.wdata[b*8 +: 8];
				nxt_st.ctrl[31:12]    = 20'h0_0000;
				nxt_st.ctrl[CTRL_MRST] = 1'b0;
				if (st_ff.wstrb[0] && st_ff.wdata[CTRL_MRST])
					nxt_st.clr = 1'b1;
			end
			else if (st_ff.awaddr != STATUS_ADDR && st_ff.awaddr != LEVEL_A_ADDR
				&& st_ff.awaddr != LEVEL_B_ADDR)
				nxt_st.bresp = RESP_SLVERR;
		end
		if (st_ff.bvalid && s_axi_bready_i)
			nxt_st.bvalid = 1'b0;
		// Read channel
		if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = rd_word;
			nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (st_ff.rvalid && s_axi_rready_i)
			nxt_st.rvalid = 1'b0;
		// Two-entry buffer of flag vectors; a full buffer defers reporting
		if (pop)
			nxt_st.buf_data[0] = st_ff.buf_data[1];
		if (push)
		begin
			nxt_st.buf_data[wr_slot[0]] = flag_raw;
			nxt_st.last_sent            = flag_raw;
		end
		nxt_st.buf_cnt = st_ff.buf_cnt + 2'(push) - 2'(pop);
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_ff           <= '0;
			st_ff.ctrl      <= CTRL_RST;
			st_ff.offset    <= {NF{OFFSET_RST}};
			st_ff.boot      <= 1'b1;
			st_ff.quad      <= 1'b1;
			st_ff.last_sent <= '1;
			// Read selects idle high; their stages start there
			st_ff.sy1[SY_RSEL_N]  <= '1;
			st_ff.sy2[SY_RSEL_N]  <= '1;
			st_ff.sy3[SY_RSEL_N]  <= '1;
			st_ff.filt[SY_RSEL_N] <= '1;
		end
		else
			st_ff <= nxt_st;
	end

	// Outputs
	assign almost_full_n_o = flag_raw;
	assign echo_read_clk_o = st_ff.echo;
	assign evt_valid_o     = (st_ff.buf_cnt != 2'd0);
	assign evt_data_o      = st_ff.buf_data[0];
	assign s_axi_awready_o = !st_ff.aw_hold && !st_ff.bvalid;
	assign s_axi_wready_o  = !st_ff.w_hold && !st_ff.bvalid;
	assign s_axi_bvalid_o  = st_ff.bvalid;
	assign s_axi_bresp_o   = st_ff.bresp;
	assign s_axi_arready_o = !st_ff.rvalid;
	assign s_axi_rvalid_o  = st_ff.rvalid;
	assign s_axi_rdata_o   = st_ff.rdata;
	assign s_axi_rresp_o   = st_ff.rresp;

	property p_echo_follows;
		@(posedge clk_i) disable iff (reset_i)
		rise[SY_RCLK][0] ##1 1'b1 |=> echo_read_clk_o[0];
	endproperty
	a_echo_follows: assert property (p_echo_follows)
		else $error("echo clock did not follow");

	property p_dual_flags;
		@(posedge clk_i) disable iff (reset_i)
		!st_ff.quad |-> almost_full_n_o[1] && almost_full_n_o[3] && !echo_read_clk_o[1];
	endproperty
	a_dual_flags: assert property (p_dual_flags)
		else $error("absent FIFO shows activity");

	property p_evt_hold;
		@(posedge clk_i) disable iff (reset_i)
		evt_valid_o && !evt_ready_i |=> evt_valid_o && $stable(evt_data_o);
	endproperty
	a_evt_hold: assert property (p_evt_hold)
		else $error("event word dropped under stall");

	property p_mode_capture;
		@(posedge clk_i) disable iff (reset_i)
		st_ff.clr |=> st_ff.first_word_fallthrough_mode == $past(st_ff.ctrl[CTRL_MODE]);
	endproperty
	a_mode_capture: assert property (p_mode_capture)
		else $error("mode not captured at clear");

	property p_quad_capture;
		@(posedge clk_i) disable iff (reset_i)
		st_ff.clr |=> st_ff.quad == $past(st_ff.ctrl[CTRL_QUAD]);
	endproperty
	a_quad_capture: assert property (p_quad_capture)
		else $error("quad mode not captured at clear");

	property p_absent_idle;
		@(posedge clk_i) disable iff (reset_i)
		!st_ff.quad |-> level[1] == 16'h0000 && level[3] == 16'h0000;
	endproperty
	a_absent_idle: assert property (p_absent_idle)
		else $error("absent FIFO holds words");

	property p_clear_flags;
		@(posedge clk_i) disable iff (reset_i)
		st_ff.clr |=> almost_full_n_o == {NF{1'b1}};
	endproperty
	a_clear_flags: assert property (p_clear_flags)
		else $error("flags not high after master reset");

	property p_echo_low;
		@(posedge clk_i) disable iff (reset_i)
		!st_ff.filt[SY_RCLK][0] |=> !echo_read_clk_o[0];
	endproperty
	a_echo_low: assert property (p_echo_low)
		else $error("echo clock high while read clock low");

	property p_evt_push;
		@(posedge clk_i) disable iff (reset_i)
		push |=> evt_valid_o;
	endproperty
	a_evt_push: assert property (p_evt_push)
		else $error("flag change not offered");
endmodule

// ===== dv/far_end.sv
// Writer and reader model that drives the link pins of each FIFO
`timescale 1ns/10ps
module far_end(
	output logic [3:0]	wr_clk_o,	// Write clocks
	output logic [3:0]	wr_en_o,	// Write enables
	output logic [3:0]	rd_clk_o,	// Read clocks
	output logic [3:0]	rd_en_o,	// Read enables
	output logic [3:0]	rsel_n_o	// Read selects, low active
);
	// Clocks rest low and ports idle between bursts
	initial
	begin
		wr_clk_o = '0;
		wr_en_o = '0;
		rd_clk_o = '0;
		rd_en_o = '0;
		rsel_n_o = '1;
	end
	// Run n link cycles of 125 ns on one port; en marks a transfer
	task automatic run(input bit rd, input int f, input int n, input logic en);
		#3;
		wr_en_o[f] = !rd && en;
		rd_en_o[f] = rd && en;
		rsel_n_o[f] = !(rd && en);
		// Enable leads the first rising edge and outlasts the last falling edge
		repeat (n)
		begin
			#62.5;
			wr_clk_o[f] = !rd;
			rd_clk_o[f] = rd;
			#62.5;
			wr_clk_o[f] = 1'b0;
			rd_clk_o[f] = 1'b0;
		end
		#20;
		wr_en_o[f] = 1'b0;
		rd_en_o[f] = 1'b0;
		rsel_n_o[f] = 1'b1;
	endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the almost-full flag and echo clock block
`timescale 1ns/10ps
module tb;
	import almost_full_pkg::*;
	localparam int	DEP = 16;	// Small depth keeps fills short
	logic		clk, rst, ev_rdy, awv, wv, bry, arv, rry;
	logic [7:0]	awa, ara;
	logic [31:0]	wd;
	wire		ev_v, awr, wr, bv, arr, rv;
	wire [1:0]	br, rr;
	wire [31:0]	rdat;
	wire [3:0]	wck, wen, rck, ren, rsn, afn, ecl, ev_d;
	int		error_cnt, n_tests;

	almost_full_echo #(.DEPTH(DEP)) almost_full_echo_inst (.clk_i(clk), .reset_i(rst),
		.wr_clk_i(wck), .wr_en_i(wen), .rd_clk_i(rck), .rd_en_i(ren),
		.read_select_n_i(rsn), .almost_full_n_o(afn), .echo_read_clk_o(ecl),
		.evt_valid_o(ev_v), .evt_ready_i(ev_rdy), .evt_data_o(ev_d),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rry));
	far_end far_end_inst (.wr_clk_o(wck), .wr_en_o(wen), .rd_clk_o(rck), .rd_en_o(ren),
		.rsel_n_o(rsn));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever
			#5 clk = !clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register write; both channels offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
			if (bv)
			begin
				chk(32'(br), 32'(er));
				break;
			end
		end
		bry <= 1'b0;
		@(posedge clk);
	endtask
	// Register read with expected data and response
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
			begin
				chk(rdat, ed);
				chk(32'(rr), 32'(er));
				break;
			end
		end
		rry <= 1'b0;
		@(posedge clk);
	endtask
	// Link burst, then let the synchronisers settle
	task automatic lk(input bit rd, input int f, input int n, input logic en);
		far_end_inst.run(rd, f, n, en);
		repeat (8) @(posedge clk);
	endtask
	// Master reset with new control word; offsets 4 and 6 give thresholds 12 and 10, or 13 and 11 in fall-through mode
	task automatic mrst(input logic [31:0] c);
		axw(CTRL_ADDR, c, RESP_OKAY);
		repeat (4) @(posedge clk);
		axw(OFFSET0_ADDR, 32'h0000_0004, RESP_OKAY);
		axw(8'h04, 32'h0000_0006, RESP_OKAY);
	endtask
	task automatic pop(input logic [3:0] exp);
		ev_rdy <= 1'b1;
		do
			@(posedge clk);
		while (ev_v !== 1'b1);
		chk(32'(ev_d), 32'(exp));
		ev_rdy <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_regs;
		axr(CTRL_ADDR, CTRL_RST, RESP_OKAY);
		axr(OFFSET0_ADDR, {16'h0000, OFFSET_RST}, RESP_OKAY);
		axr(STATUS_ADDR, 32'h0000_002F, RESP_OKAY);
		axr(8'h20, 32'h0000_0000, RESP_SLVERR);
		axw(8'h20, 32'h0000_0001, RESP_SLVERR);
		$display("registers done");
	endtask
	task automatic t_std;
		mrst(32'h0000_0FFD);
		lk(0, 0, 11, 1'b1);
		chk(32'(afn), 32'h0000_000F);
		lk(0, 0, 1, 1'b1);
		chk(32'(afn), 32'h0000_000E);
		lk(0, 1, 10, 1'b1);
		chk(32'(afn), 32'h0000_000C);
		axr(LEVEL_A_ADDR, 32'h000A_000C, RESP_OKAY);
		pop(4'hE);
		pop(4'hC);
		lk(1, 0, 1, 1'b1);
		chk(32'(afn), 32'h0000_000C);
		lk(0, 0, 1, 1'b0);
		chk(32'(afn), 32'h0000_000D);
		pop(4'hD);
		$display("standard mode done");
	endtask
	task automatic t_async;
		mrst(32'h0000_0FFC);
		chk(32'(afn), 32'h0000_000F);
		lk(0, 0, 12, 1'b1);
		chk(32'(afn), 32'h0000_000E);
		lk(1, 0, 1, 1'b1);
		chk(32'(afn), 32'h0000_000F);
		$display("async mode done");
	endtask
	task automatic t_first_word_fallthrough_mode;
		mrst(32'h0000_0FFF);
		axr(CTRL_ADDR, 32'h0000_0FF7, RESP_OKAY);
		axr(STATUS_ADDR, 32'h0000_003F, RESP_OKAY);
		lk(0, 0, 12, 1'b1);
		chk(32'(afn), 32'h0000_000F);
		lk(0, 0, 1, 1'b1);
		chk(32'(afn), 32'h0000_000E);
		$display("fall-through done");
	endtask
	task automatic t_echo;
		int	n;
		logic	prev;
		n = 0;
		prev = 1'b0;
		fork
			far_end_inst.run(1, 2, 4, 1'b0);
			repeat (60)
			begin
				@(posedge clk);
				if (ecl[2] && !prev)
					n++;
				prev = ecl[2];
			end
		join
		chk(32'(n), 32'd4);
		chk(32'(ecl[0]), 32'h0000_0000);
		$display("echo clock done");
	endtask
	task automatic t_dual;
		mrst(32'h0000_0FF9);
		axr(STATUS_ADDR, 32'h0000_000F, RESP_OKAY);
		lk(0, 1, 10, 1'b1);
		chk(32'(afn), 32'h0000_000F);
		lk(0, 0, 12, 1'b1);
		chk(32'(afn), 32'h0000_000E);
		$display("dual mode done");
	endtask
	// Double rate on port 0: crossings use the falling edges
	task automatic t_ddr;
		mrst(32'h0000_0EEC);
		lk(0, 0, 6, 1'b1);
		chk(32'(afn), 32'h0000_000F);
		lk(0, 0, 1, 1'b0);
		chk(32'(afn), 32'h0000_000E);
		axr(LEVEL_A_ADDR, 32'h0000_000C, RESP_OKAY);
		lk(1, 0, 1, 1'b1);
		chk(32'(afn), 32'h0000_000F);
		$display("double rate done");
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		error_cnt = 0;
		n_tests = 0;
		rst = 1'b1;
		ev_rdy = 1'b0;
		{awv, wv, bry, arv, rry} = '0;
		awa = '0;
		ara = '0;
		wd = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_regs;
		t_std;
		t_async;
		t_first_word_fallthrough_mode;
		t_echo;
		t_dual;
		t_ddr;
		test_done;
	end
	// Watchdog against a hung handshake
	initial
	begin
		#200_000;
		error_cnt++;
		test_done;
	end
endmodule
